// file: logic/osc_settle_timer.sv
// oscillator settling timer: counts the selected wait after a start pulse.
// assumes start arrives only while idle; the wait is BASE_CYC shifted by sel.
`timescale 1ns/1ps
module osc_settle_timer
	import power_mode_pkg::*;
#(
	parameter int unsigned BASE_CYC = SETTLE_BASE_CYC_DEF
)
(
	input  wire logic                    clk_in,    // system clock
	input  wire logic                    resetn_in, // async reset, low
	input  wire logic                    start_in,  // begin a wait
	input  wire logic                    abort_in,  // drop a running wait
	input  wire logic [SETTLE_SEL_W-1:0] sel_in,    // wait select
	output logic                         busy_out,  // wait running
	output logic                         done_out   // wait elapsed, pulse
);

	logic [SETTLE_CNT_W-1:0] cnt_q, cnt_d;
	logic                    busy_q, busy_d;
	logic                    done_q, done_d;

	always_comb
	begin
		cnt_d  = cnt_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (abort_in)
		begin
			busy_d = 1'b0;
		end
		else if (start_in && !busy_q)
		begin
			cnt_d  = SETTLE_CNT_W'(BASE_CYC << sel_in) - SETTLE_CNT_W'(1);
			busy_d = 1'b1;
		end
		else if (busy_q)
		begin
			if (cnt_q == '0)
			begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
			else
			begin
				cnt_d = cnt_q - SETTLE_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			cnt_q  <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign busy_out = busy_q;
	assign done_out = done_q;

endmodule

// file: logic/power_mode_ctrl.sv
// system power mode controller: active, sleep, standby, watch, subactive.
// assumes the CPU pulses sleep_exec_in as its SLEEP instruction completes and
// that interrupt enables and the global mask come from same-clock logic.
`timescale 1ns/1ps
module power_mode_ctrl
	import power_mode_pkg::*;
#(
	parameter int unsigned SETTLE_BASE_CYC = SETTLE_BASE_CYC_DEF
)
(
	input  wire logic              clk_in,            // system clock, 50 MHz
	input  wire logic              resetn_in,         // async reset, low
	input  wire logic [ADDR_W-1:0] addr_in,           // register address
	input  wire logic [DATA_W-1:0] wdata_in,          // register write data
	input  wire logic              wr_in,             // write strobe
	input  wire logic              rd_in,             // read strobe
	output logic      [DATA_W-1:0] rdata_out,         // read data, next cycle
	input  wire logic              sleep_exec_in,     // SLEEP completed, pulse
	input  wire logic              global_mask_in,    // CPU interrupt mask
	input  wire wake_src_s         irq_enable_in,     // per-source enables
	input  wire logic              ext_int_zero_in,   // pin, async
	input  wire logic              ext_int_one_in,    // pin, async
	input  wire logic              chip_init_pin_n_in, // init pin, async, low
	input  wire logic              timer_a_ovf_in,    // timer A overflow
	input  wire logic              subclk_tick_in,    // subclock enable pulse
	output power_mode_e            mode_out,          // current mode
	output gate_ctl_s              gate_out,          // clock and block gating
	output logic                   cpu_reset_out,     // hold CPU in reset
	output logic                   irq_start_out,     // start handler, pulse
	output wake_src_s              wake_src_out       // source that woke us
);

	// pin synchronisers: stage one feeds stage two only
	logic [2:0] pin_s1_q, pin_s2_q;
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			pin_s1_q <= 3'h4;
			pin_s2_q <= 3'h4;
		end
		else
		begin
			pin_s1_q <= {chip_init_pin_n_in, ext_int_one_in, ext_int_zero_in};
			pin_s2_q <= pin_s1_q;
		end
	end

	logic ext0_req, ext1_req, init_low;
	assign ext0_req = pin_s2_q[0];
	assign ext1_req = pin_s2_q[1];
	assign init_low = !pin_s2_q[2];

	// control register
	logic [DATA_W-1:0] ctrl_q, ctrl_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic                    deep_halt_select;
	logic                    timebase_select_bit;
	logic                    low_speed_run_select;
	logic                    direct_wake_select;
	logic [SETTLE_SEL_W-1:0] osc_settle_wait_sel;
	assign deep_halt_select     = ctrl_q[CTRL_DEEP_HALT];
	assign timebase_select_bit  = ctrl_q[CTRL_TIMEBASE];
	assign low_speed_run_select = ctrl_q[CTRL_LOW_SPEED];
	assign direct_wake_select   = ctrl_q[CTRL_DIRECT];
	assign osc_settle_wait_sel  = ctrl_q[CTRL_SETTLE_LSB +: SETTLE_SEL_W];

	// mode state
	power_mode_e mode_q, mode_d;
	logic        settling_q, settling_d;
	logic        direct_pend_q, direct_pend_d;
	logic        start_q, start_d;
	wake_src_s   src_q, src_d;
	logic        settle_start;
	logic        settle_done;

	// accepted requests: enabled and not globally masked
	logic acc_zero, acc_one, acc_tma, acc_direct;
	assign acc_zero   = ext0_req && irq_enable_in.ext_int_zero && !global_mask_in;
	assign acc_one    = ext1_req && irq_enable_in.ext_int_one && !global_mask_in;
	assign acc_tma    = timer_a_ovf_in && irq_enable_in.timer_a && !global_mask_in;
	assign acc_direct = subclk_tick_in && irq_enable_in.direct && !global_mask_in;

	osc_settle_timer #(
		.BASE_CYC (SETTLE_BASE_CYC)
	) u_settle (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.start_in  (settle_start),
		.abort_in  (init_low),
		.sel_in    (osc_settle_wait_sel),
		.busy_out  (),
		.done_out  (settle_done)
	);

	always_comb
	begin
		mode_d        = mode_q;
		settling_d    = settling_q;
		direct_pend_d = direct_pend_q;
		start_d       = 1'b0;
		src_d         = src_q;
		settle_start  = 1'b0;
		if (init_low)
		begin
			// init pin wins over every mode and drops any pending wait
			mode_d        = MODE_ACTIVE;
			settling_d    = 1'b0;
			direct_pend_d = 1'b0;
		end
		else
		begin
			unique case (mode_q)
				MODE_ACTIVE:
				begin
					if (sleep_exec_in)
					begin
						if (!deep_halt_select)
							mode_d = MODE_SLEEP;
						else if (!timebase_select_bit)
							mode_d = MODE_STANDBY;
						else
							mode_d = MODE_WATCH;
					end
				end
				MODE_SLEEP:
				begin
					// clock never stopped, so no settling wait is needed
					if (acc_zero || acc_one || acc_tma)
					begin
						mode_d  = MODE_ACTIVE;
						start_d = 1'b1;
						src_d   = '{direct: 1'b0, timer_a: acc_tma,
							ext_int_one: acc_one, ext_int_zero: acc_zero};
					end
				end
				MODE_STANDBY:
				begin
					if (settling_q && settle_done)
					begin
						mode_d     = MODE_ACTIVE;
						settling_d = 1'b0;
						start_d    = 1'b1;
					end
					else if (!settling_q && (acc_zero || acc_one))
					begin
						settle_start = 1'b1;
						settling_d   = 1'b1;
						src_d        = '{direct: 1'b0, timer_a: 1'b0,
							ext_int_one: acc_one, ext_int_zero: acc_zero};
					end
				end
				MODE_WATCH:
				begin
					if (settling_q && settle_done)
					begin
						mode_d        = MODE_ACTIVE;
						settling_d    = 1'b0;
						direct_pend_d = 1'b0;
						start_d       = 1'b1;
					end
					else if (!settling_q && direct_pend_q && acc_direct)
					begin
						// direct transfer request lands on a subclock tick
						settle_start = 1'b1;
						settling_d   = 1'b1;
						src_d        = '{direct: 1'b1, timer_a: 1'b0,
							ext_int_one: 1'b0, ext_int_zero: 1'b0};
					end
					else if (!settling_q && !direct_pend_q && (acc_zero || acc_tma))
					begin
						src_d = '{direct: 1'b0, timer_a: acc_tma,
							ext_int_one: 1'b0, ext_int_zero: acc_zero};
						if (low_speed_run_select)
						begin
							mode_d  = MODE_SUBACTIVE;
							start_d = 1'b1;
						end
						else
						begin
							settle_start = 1'b1;
							settling_d   = 1'b1;
						end
					end
				end
				MODE_SUBACTIVE:
				begin
					if (sleep_exec_in)
					begin
						// with low-speed run set, direct transfer is not possible
						mode_d        = MODE_WATCH;
						direct_pend_d = direct_wake_select && !low_speed_run_select;
					end
				end
				default:
				begin
					mode_d = MODE_ACTIVE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			mode_q        <= MODE_ACTIVE;
			settling_q    <= 1'b0;
			direct_pend_q <= 1'b0;
			start_q       <= 1'b0;
			src_q         <= '0;
		end
		else
		begin
			mode_q        <= mode_d;
			settling_q    <= settling_d;
			direct_pend_q <= direct_pend_d;
			start_q       <= start_d;
			src_q         <= src_d;
		end
	end

	// register port
	always_comb
	begin
		ctrl_d  = ctrl_q;
		rdata_d = '0;
		if (wr_in && addr_in == OFS_CTRL)
			ctrl_d = wdata_in;
		if (rd_in)
		begin
			if (addr_in == OFS_CTRL)
				rdata_d = ctrl_q;
			else if (addr_in == OFS_STATUS)
				rdata_d = {init_low, direct_pend_q, settling_q, mode_q};
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ctrl_q  <= CTRL_RESET;
			rdata_q <= '0;
		end
		else
		begin
			ctrl_q  <= ctrl_d;
			rdata_q <= rdata_d;
		end
	end

	// gating decode from the registered mode
	logic in_active, in_sleep, in_deep;
	assign in_active = (mode_q == MODE_ACTIVE);
	assign in_sleep  = (mode_q == MODE_SLEEP);
	assign in_deep   = (mode_q == MODE_STANDBY) || (mode_q == MODE_WATCH)
		|| (mode_q == MODE_SUBACTIVE);

	always_comb
	begin
		gate_out.sysclk_en      = in_active || in_sleep || settling_q;
		gate_out.osc_run        = in_active || in_sleep || settling_q;
		gate_out.cpu_step       = (in_active && !init_low)
			|| (mode_q == MODE_SUBACTIVE && subclk_tick_in);
		gate_out.periph_run     = in_active;
		gate_out.periph_out_rst = in_deep || in_sleep;
		gate_out.timer_a_run    = !(mode_q == MODE_STANDBY);
		gate_out.port_hold      = in_sleep;
		gate_out.port_hiz       = in_deep;
		gate_out.hv_pmos_off    = in_deep;
	end

	assign mode_out      = mode_q;
	assign cpu_reset_out = init_low;
	assign irq_start_out = start_q;
	assign wake_src_out  = src_q;
	assign rdata_out     = rdata_q;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);
	a_one_hot_mode: assert property ($onehot(mode_q))
		else $error("mode register not one-hot");
	a_active_step: assert property (in_active && !init_low |-> gate_out.cpu_step)
		else $error("CPU not stepping in active mode");
	a_sleep_entry: assert property (in_active && sleep_exec_in && !deep_halt_select
		&& !init_low |=> mode_q == MODE_SLEEP)
		else $error("sleep not entered");
	a_standby_entry: assert property (in_active && sleep_exec_in && deep_halt_select
		&& !timebase_select_bit && !init_low |=> mode_q == MODE_STANDBY)
		else $error("standby not entered");
	a_watch_entry: assert property (in_active && sleep_exec_in && deep_halt_select
		&& timebase_select_bit && !init_low |=> mode_q == MODE_WATCH)
		else $error("watch not entered");
	a_sleep_gating: assert property (in_sleep |-> !gate_out.cpu_step
		&& gate_out.sysclk_en && gate_out.port_hold && gate_out.timer_a_run)
		else $error("sleep gating wrong");
	a_standby_halt: assert property (mode_q == MODE_STANDBY && !settling_q
		|-> !gate_out.sysclk_en && !gate_out.periph_run && gate_out.periph_out_rst)
		else $error("standby not halted");
	a_deep_ports: assert property (in_deep |-> gate_out.port_hiz && gate_out.hv_pmos_off)
		else $error("ports not released in deep mode");
	a_sleep_wake: assert property (in_sleep && !init_low && (acc_zero || acc_one || acc_tma)
		|=> in_active && irq_start_out && gate_out.sysclk_en)
		else $error("sleep wake missed");
	a_masked_stay: assert property (in_sleep && global_mask_in && !init_low
		|=> in_sleep)
		else $error("masked wake ended sleep");
	a_init_wins: assert property (init_low |-> cpu_reset_out ##1 in_active)
		else $error("init pin did not reset");
	a_subactive_entry: assert property (mode_q == MODE_WATCH && !settling_q && !direct_pend_q
		&& (acc_zero || acc_tma) && low_speed_run_select && !init_low
		|=> mode_q == MODE_SUBACTIVE)
		else $error("subactive not entered");

endmodule

// file: logic/power_mode_pkg.sv
// power mode controller package: register map, field layout, reset values,
// mode codes, timing constants and the carriers shared by the controller files.
// assumes a 50 MHz system clock and a single-cycle register port.
package power_mode_pkg;

	// register port geometry
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;

	// register offsets
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h1;

	// control register field positions
	localparam int unsigned CTRL_DEEP_HALT  = 0;
	localparam int unsigned CTRL_TIMEBASE   = 1;
	localparam int unsigned CTRL_LOW_SPEED  = 2;
	localparam int unsigned CTRL_DIRECT     = 3;
	localparam int unsigned CTRL_SETTLE_LSB = 4;
	localparam int unsigned SETTLE_SEL_W    = 3;

	// status register field positions (mode code sits in bits 4:0)
	localparam int unsigned STAT_SETTLING = 5;
	localparam int unsigned STAT_DIRECT   = 6;
	localparam int unsigned STAT_CPU_RST  = 7;

	localparam logic [7:0] CTRL_RESET = 8'h00;

	// oscillator settling: base wait, doubled per step of the select field
	localparam int unsigned CLK_PERIOD_NS       = 20;
	localparam int unsigned SETTLE_BASE_NS      = 163840;
	localparam int unsigned SETTLE_BASE_CYC_DEF =
		(SETTLE_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SETTLE_CNT_W        = 32;

	typedef enum logic [4:0] {
		MODE_ACTIVE    = 5'b00001,
		MODE_SLEEP     = 5'b00010,
		MODE_STANDBY   = 5'b00100,
		MODE_WATCH     = 5'b01000,
		MODE_SUBACTIVE = 5'b10000
	} power_mode_e;

	// per-source interrupt enables as held by the interrupt controller
	typedef struct packed {
		logic direct;
		logic timer_a;
		logic ext_int_one;
		logic ext_int_zero;
	} wake_src_s;

	// gating controls handed to the clock tree, CPU, ports and peripherals
	typedef struct packed {
		logic sysclk_en;
		logic osc_run;
		logic cpu_step;
		logic periph_run;
		logic periph_out_rst;
		logic timer_a_run;
		logic port_hold;
		logic port_hiz;
		logic hv_pmos_off;
	} gate_ctl_s;

endpackage

// file: verif/cpu_model.sv
// cpu core and subclock stand-in: finishes SLEEP only when the core may step,
// counts handler entries and makes the subclock enable tick.
// assumes one system clock shared with the power mode controller.
`timescale 1ns/1ps
module cpu_model
#(
	parameter int unsigned TICK_DIV = 8
)
(
	input  wire logic       clk_in,          // system clock
	input  wire logic       resetn_in,       // async reset, low
	input  wire logic       go_in,           // request a SLEEP instruction
	input  wire logic       cpu_step_in,     // core may advance this cycle
	input  wire logic       irq_start_in,    // handler entry pulse
	output logic            sleep_exec_out,  // SLEEP finished, pulse
	output logic            subclk_tick_out, // subclock enable
	output logic [7:0]      handlers_out     // handler entries seen
);
	logic       pend_q;
	logic [3:0] div_q;

	// a halted core cannot finish an instruction, so the request waits for a step
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			pend_q <= 1'b0;
			sleep_exec_out <= 1'b0;
			div_q <= 4'h0;
			subclk_tick_out <= 1'b0;
			handlers_out <= 8'h00;
		end
		else
		begin
			pend_q <= go_in | (pend_q & ~cpu_step_in);
			sleep_exec_out <= pend_q & cpu_step_in;
			div_q <= (div_q == 4'(TICK_DIV - 1)) ? 4'h0 : div_q + 4'h1;
			subclk_tick_out <= (div_q == 4'h0);
			handlers_out <= handlers_out + {7'h00, irq_start_in};
		end
	end
endmodule

// file: verif/tb.sv
// self-checking bench for the power mode controller: walks every mode change but the init pin exit from standby, watch and subactive
// assumes power_mode_pkg, power_mode_ctrl and cpu_model are compiled first
`timescale 1ns/1ps
module tb;
	import power_mode_pkg::*;
	localparam int unsigned BASE = 4;
	logic              clk_in;
	logic              resetn_in;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              wr;
	logic              rd;
	logic [DATA_W-1:0] rdata;
	logic              sleep_exec;
	logic              gmask;
	wake_src_s         en;
	logic              ext0;
	logic              ext1;
	logic              init_n;
	logic              tovf;
	logic              tick;
	logic              go;
	power_mode_e       mode;
	gate_ctl_s         gate;
	logic              cpu_rst;
	logic              irq_start;
	wake_src_s         wsrc;
	logic [7:0]        handlers;
	logic [7:0]        d;
	int                n;
	int                errors;
	int                checks;

	power_mode_ctrl #(.SETTLE_BASE_CYC(BASE)) power_mode_ctrl_i (
		.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .rdata_out(rdata), .sleep_exec_in(sleep_exec),
		.global_mask_in(gmask), .irq_enable_in(en), .ext_int_zero_in(ext0),
		.ext_int_one_in(ext1), .chip_init_pin_n_in(init_n), .timer_a_ovf_in(tovf),
		.subclk_tick_in(tick), .mode_out(mode), .gate_out(gate), .cpu_reset_out(cpu_rst),
		.irq_start_out(irq_start), .wake_src_out(wsrc));

	cpu_model #(.TICK_DIV(8)) cpu_model_i (
		.clk_in(clk_in), .resetn_in(resetn_in), .go_in(go), .cpu_step_in(gate.cpu_step),
		.irq_start_in(irq_start), .sleep_exec_out(sleep_exec), .subclk_tick_out(tick),
		.handlers_out(handlers));

	initial
	begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	task automatic finish_test();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask

	// counts sampled cycles until the mode shows up; a dead wait ends the run
	task automatic wait_mode(input power_mode_e m, input int bound);
		n = 0;
		while (mode !== m)
		begin
			cyc(1);
			n++;
			if (n > bound)
			begin
				errors++;
				$display("unexpected at %0t: mode wait ran out", $time);
				finish_test();
			end
		end
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_in);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [3:0] a);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic do_sleep();
		@(posedge clk_in);
		go <= 1'b1;
		@(posedge clk_in);
		go <= 1'b0;
	endtask

	task automatic t_reset();
		chk(mode, MODE_ACTIVE);
		chk({gate.sysclk_en, gate.cpu_step, gate.port_hiz}, 3'b110);
		reg_rd(OFS_CTRL);
		chk(d, CTRL_RESET);
		reg_wr(OFS_CTRL, 8'hA5);
		reg_wr(4'h2, 8'hFF);
		reg_rd(OFS_CTRL);
		chk(d, 8'hA5);
		reg_rd(4'h2);
		chk(d, 8'h00);
		reg_rd(OFS_STATUS);
		chk(d[4:0], MODE_ACTIVE);
		cyc(1);
		chk(rdata, 8'h00);
	endtask

	task automatic t_sleep();
		reg_wr(OFS_CTRL, 8'h00);
		do_sleep();
		wait_mode(MODE_SLEEP, 8);
		chk({gate.sysclk_en, gate.cpu_step, gate.port_hiz, gate.timer_a_run}, 4'b1001);
		chk({gate.port_hold, gate.periph_out_rst}, 2'b11);
		@(posedge clk_in);
		gmask <= 1'b1;
		ext0 <= 1'b1;
		cyc(8);
		chk(mode, MODE_SLEEP);
		@(posedge clk_in);
		en <= 4'b0110;
		gmask <= 1'b0;
		cyc(8);
		chk(mode, MODE_SLEEP);
		@(posedge clk_in);
		ext0 <= 1'b0;
		cyc(4);
		@(posedge clk_in);
		en <= 4'b0111;
		ext0 <= 1'b1;
		wait_mode(MODE_ACTIVE, 6);
		chk({irq_start, gate.sysclk_en, wsrc.ext_int_zero}, 3'b111);
		cyc(1);
		chk(irq_start, 1'b0);
		@(posedge clk_in);
		ext0 <= 1'b0;
	endtask

	task automatic t_standby();
		reg_wr(OFS_CTRL, 8'h11);
		do_sleep();
		wait_mode(MODE_STANDBY, 8);
		chk({gate.sysclk_en, gate.cpu_step, gate.port_hiz, gate.timer_a_run}, 4'b0010);
		chk(gate.osc_run, 1'b0);
		chk({gate.hv_pmos_off, gate.periph_out_rst, gate.periph_run}, 3'b110);
		@(posedge clk_in);
		tovf <= 1'b1;
		@(posedge clk_in);
		tovf <= 1'b0;
		cyc(6);
		chk(mode, MODE_STANDBY);
		@(posedge clk_in);
		ext1 <= 1'b1;
		wait_mode(MODE_ACTIVE, 40);
		chk(n >= (BASE << 1) + 3 && n <= (BASE << 1) + 5, 1'b1);
		chk(wsrc.ext_int_one, 1'b1);
		@(posedge clk_in);
		ext1 <= 1'b0;
	endtask

	task automatic t_watch();
		reg_wr(OFS_CTRL, 8'h07);
		do_sleep();
		wait_mode(MODE_WATCH, 8);
		chk({gate.sysclk_en, gate.cpu_step, gate.port_hiz, gate.timer_a_run}, 4'b0011);
		chk({gate.hv_pmos_off, gate.periph_out_rst}, 2'b11);
		@(posedge clk_in);
		ext1 <= 1'b1;
		cyc(8);
		chk(mode, MODE_WATCH);
		@(posedge clk_in);
		ext1 <= 1'b0;
		tovf <= 1'b1;
		@(posedge clk_in);
		tovf <= 1'b0;
		// the mode flips at this very edge; look after it so the start pulse is still up
		#1;
		wait_mode(MODE_SUBACTIVE, 6);
		chk({irq_start, gate.port_hiz, gate.periph_run, gate.timer_a_run}, 4'b1101);
		repeat (16)
		begin
			chk(gate.cpu_step, tick);
			cyc(1);
		end
		reg_wr(OFS_CTRL, 8'h03);
		do_sleep();
		wait_mode(MODE_WATCH, 40);
		@(posedge clk_in);
		tovf <= 1'b1;
		@(posedge clk_in);
		tovf <= 1'b0;
		wait_mode(MODE_ACTIVE, 40);
		chk(n >= BASE + 1 && n <= BASE + 4, 1'b1);
		chk(wsrc.timer_a, 1'b1);
	endtask

	task automatic t_init();
		reg_wr(OFS_CTRL, 8'h00);
		do_sleep();
		wait_mode(MODE_SLEEP, 8);
		@(posedge clk_in);
		init_n <= 1'b0;
		wait_mode(MODE_ACTIVE, 6);
		chk(cpu_rst, 1'b1);
		@(posedge clk_in);
		init_n <= 1'b1;
		cyc(4);
		chk(cpu_rst, 1'b0);
		chk(handlers, 8'h04);
	endtask

	// subactive SLEEP with direct transfer set: watch, then active after a settling wait started on a subclock tick
	task automatic t_direct();
		reg_wr(OFS_CTRL, 8'h07);
		do_sleep();
		wait_mode(MODE_WATCH, 8);
		@(posedge clk_in);
		tovf <= 1'b1;
		@(posedge clk_in);
		tovf <= 1'b0;
		#1;
		wait_mode(MODE_SUBACTIVE, 6);
		reg_wr(OFS_CTRL, 8'h0B);
		@(posedge clk_in);
		en <= 4'b1111;
		do_sleep();
		wait_mode(MODE_WATCH, 40);
		reg_rd(OFS_STATUS);
		chk(d[6], 1'b1);
		wait_mode(MODE_ACTIVE, 40);
		chk({irq_start, wsrc.direct}, 2'b11);
		@(posedge clk_in);
		en <= 4'b0111;
	endtask

	initial
	begin
		errors = 0;
		checks = 0;
		resetn_in = 1'b0;
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
		gmask = 1'b0;
		en = 4'b0111;
		ext0 = 1'b0;
		ext1 = 1'b0;
		init_n = 1'b1;
		tovf = 1'b0;
		go = 1'b0;
		cyc(20);
		@(posedge clk_in);
		resetn_in <= 1'b1;
		cyc(3);
		t_reset();
		t_sleep();
		t_standby();
		t_watch();
		t_init();
		t_direct();
		finish_test();
	end
endmodule
